// ===== logic/twsp_pkg.sv
/*
 two-wire slave port package: register indices, field positions,
 reset values, phase codes and carrier structs.
 assumes: used by twsp_top and twsp_line_sync, referenced by full name.
*/
package twsp_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL      = 4'h0;
    localparam logic [3:0] IDX_OWN_ADDR  = 4'h1;
    localparam logic [3:0] IDX_BYTE_BUF  = 4'h2;
    localparam logic [3:0] IDX_PORT_FUNC = 4'h3;
    localparam int         ADDR_LSB      = 2;
    // control register fields
    localparam int BIT_LINK_EN   = 7;
    localparam int BIT_EVENT     = 6;
    localparam int BIT_BCAST_HIT = 4;
    localparam int BIT_ACK_ALLOW = 3;
    localparam int PHASE_MSB     = 2;
    // own address register fields
    localparam int OWN_ADDR_MSB  = 7;
    localparam int OWN_ADDR_LSB  = 1;
    localparam int BIT_GC_EN     = 0;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [1:0] RESET_FUNC   = 2'h0;
    localparam logic [1:0] FUNC_TWO_WIRE = 2'h2;
    localparam logic [6:0] GENERAL_CALL = 7'h00;
    localparam logic [3:0] LAST_BIT     = 4'h7;
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    // phase field codes
    localparam logic [2:0] PH_IDLE      = 3'h0;
    localparam logic [2:0] PH_ADDR      = 3'h1;
    localparam logic [2:0] PH_RECV      = 3'h2;
    localparam logic [2:0] PH_SEND      = 3'h3;
    localparam logic [2:0] PH_NACK_WAIT = 3'h4;
    localparam logic [2:0] PH_AA_WAIT   = 3'h5;

    typedef struct packed {
        logic clk_rise;
        logic clk_fall;
        logic start_seen;
        logic stop_seen;
        logic data_lvl;
    } twsp_line_ev_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } twsp_apb_req_t;
endpackage : twsp_pkg

// ===== logic/twsp_line_sync.sv
/*
 two-wire line synchroniser and event finder.
 assumes: clock and data lines arrive from outside the sys_clk domain.
*/
`timescale 1ns/100ps
module twsp_line_sync (
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output twsp_pkg::twsp_line_ev_t     ev
);
    logic [1:0] scl_meta_reg;
    logic [1:0] sda_meta_reg;
    logic       scl_last_reg;
    logic       sda_last_reg;

    // two flops; only the second stage is read
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_meta_reg <= 2'h3;
            sda_meta_reg <= 2'h3;
        end else begin
            scl_meta_reg <= {scl_meta_reg[0], scl_i};
            sda_meta_reg <= {sda_meta_reg[0], sda_i};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_last_reg <= 1'b1;
            sda_last_reg <= 1'b1;
        end else begin
            scl_last_reg <= scl_meta_reg[1];
            sda_last_reg <= sda_meta_reg[1];
        end
    end

    always_comb begin
        ev.clk_rise   = scl_meta_reg[1] & ~scl_last_reg;
        ev.clk_fall   = ~scl_meta_reg[1] & scl_last_reg;
        ev.start_seen = scl_meta_reg[1] & scl_last_reg
                        & sda_last_reg & ~sda_meta_reg[1];
        ev.stop_seen  = scl_meta_reg[1] & scl_last_reg
                        & ~sda_last_reg & sda_meta_reg[1];
        ev.data_lvl   = sda_meta_reg[1];
    end
endmodule : twsp_line_sync

// ===== logic/twsp_top.sv
/*
 two-wire slave port: APB registers, address match, byte receive and
 transmit under the three-bit phase machine.
 assumes: external master drives the clock line; pull-up on the data line;
 the data pin is driven low only when sda_oen is low.
*/
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module twsp_top (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oen
);
    typedef enum {
        ST_IDLE, ST_ADDR, ST_RECV, ST_SEND, ST_NACK_WAIT, ST_AA_WAIT
    } twsp_state_t;

    twsp_pkg::twsp_line_ev_t ev;
    twsp_pkg::twsp_apb_req_t req;

    twsp_state_t state_reg;
    logic        link_enable_reg;
    logic        event_flag_reg;
    logic        broadcast_hit_flag_reg;
    logic        ack_allow_reg;
    logic [6:0]  own_slave_address_reg;
    logic        general_call_enable_reg;
    logic [7:0]  byte_buffer_reg;
    logic [1:0]  port_function_select_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        drive_low_reg;
    logic        ack_slot_reg;
    logic        ack_low_reg;

    logic        wr_en;
    logic        rd_en;
    logic        active;
    logic        byte_done;
    logic        nine_done;
    logic [7:0]  ctrl_rd;
    logic [7:0]  rx_byte;
    logic        addr_hit;
    logic        gc_hit;
    logic        set_event;

    function automatic logic [2:0] phase_code(input twsp_state_t s);
        case (s)
            ST_IDLE:      phase_code = twsp_pkg::PH_IDLE;
            ST_ADDR:      phase_code = twsp_pkg::PH_ADDR;
            ST_RECV:      phase_code = twsp_pkg::PH_RECV;
            ST_SEND:      phase_code = twsp_pkg::PH_SEND;
            ST_NACK_WAIT: phase_code = twsp_pkg::PH_NACK_WAIT;
            ST_AA_WAIT:   phase_code = twsp_pkg::PH_AA_WAIT;
            default:      phase_code = twsp_pkg::PH_IDLE;
        endcase
    endfunction : phase_code

    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [3:0]  idx);
        reg_hit = (a[31:twsp_pkg::ADDR_LSB] == {26'h0, idx})
                  && (a[twsp_pkg::ADDR_LSB-1:0] == 2'h0);
    endfunction : reg_hit

    twsp_line_sync u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .ev      (ev)
    );

    assign req = '{paddr: paddr, psel: psel, penable: penable,
                   pwrite: pwrite, pwdata: pwdata};

    // zero-wait APB slave
    assign pready  = 1'b1;
    assign pslverr = req.psel & req.penable
                     & ~(reg_hit(req.paddr, twsp_pkg::IDX_CTRL)
                       | reg_hit(req.paddr, twsp_pkg::IDX_OWN_ADDR)
                       | reg_hit(req.paddr, twsp_pkg::IDX_BYTE_BUF)
                       | reg_hit(req.paddr, twsp_pkg::IDX_PORT_FUNC));
    assign wr_en = req.psel & req.penable & req.pwrite & pstrb[0];
    assign rd_en = req.psel & ~req.penable & ~req.pwrite;

    // function must be selected and the link enabled
    assign active = link_enable_reg
                    & (port_function_select_reg
                       == twsp_pkg::FUNC_TWO_WIRE);

    assign byte_done = ev.clk_fall && bit_cnt_reg == twsp_pkg::LAST_BIT;
    assign nine_done = ev.clk_fall && bit_cnt_reg == twsp_pkg::ACK_SLOT;
    assign rx_byte   = shift_reg;
    assign addr_hit  = rx_byte[7:1] == own_slave_address_reg;
    assign gc_hit    = general_call_enable_reg
                       && rx_byte[7:1] == twsp_pkg::GENERAL_CALL
                       && !rx_byte[0];

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[twsp_pkg::BIT_LINK_EN]   = link_enable_reg;
        ctrl_rd[twsp_pkg::BIT_EVENT]     = event_flag_reg;
        ctrl_rd[twsp_pkg::BIT_BCAST_HIT] = broadcast_hit_flag_reg;
        ctrl_rd[twsp_pkg::BIT_ACK_ALLOW] = ack_allow_reg;
        ctrl_rd[twsp_pkg::PHASE_MSB:0]   = phase_code(state_reg);
    end

    // read data registered in setup phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (reg_hit(req.paddr, twsp_pkg::IDX_CTRL)) begin
                prdata <= {24'h00_0000, ctrl_rd};
            end else if (reg_hit(req.paddr, twsp_pkg::IDX_OWN_ADDR)) begin
                prdata <= {24'h00_0000, own_slave_address_reg,
                           general_call_enable_reg};
            end else if (reg_hit(req.paddr, twsp_pkg::IDX_BYTE_BUF)) begin
                prdata <= {24'h00_0000, byte_buffer_reg};
            end else if (reg_hit(req.paddr, twsp_pkg::IDX_PORT_FUNC)) begin
                prdata <= {30'h0000_0000, port_function_select_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // software control fields
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            link_enable_reg          <= 1'b0;
            ack_allow_reg            <= 1'b0;
            own_slave_address_reg    <= 7'h00;
            general_call_enable_reg  <= 1'b0;
            port_function_select_reg <= twsp_pkg::RESET_FUNC;
        end else if (wr_en) begin
            if (reg_hit(req.paddr, twsp_pkg::IDX_CTRL)) begin
                link_enable_reg <= req.pwdata[twsp_pkg::BIT_LINK_EN];
                ack_allow_reg   <= req.pwdata[twsp_pkg::BIT_ACK_ALLOW];
            end
            if (reg_hit(req.paddr, twsp_pkg::IDX_OWN_ADDR)) begin
                own_slave_address_reg <= req.pwdata[twsp_pkg::OWN_ADDR_MSB:
                                                    twsp_pkg::OWN_ADDR_LSB];
                general_call_enable_reg <=
                    req.pwdata[twsp_pkg::BIT_GC_EN];
            end
            if (reg_hit(req.paddr, twsp_pkg::IDX_PORT_FUNC)) begin
                port_function_select_reg <= req.pwdata[1:0];
            end
        end
    end

    // event sources; hardware set wins over software clear
    always_comb begin
        set_event = 1'b0;
        if (active) begin
            case (state_reg)
                // match flagged at the eighth fall, before the phase moves
                ST_ADDR:  set_event = byte_done & (addr_hit | gc_hit);
                ST_RECV:  set_event = byte_done;
                ST_SEND:  set_event = byte_done;
                default:  set_event = 1'b0;
            endcase
            if (state_reg != ST_IDLE && ev.start_seen) begin
                set_event = 1'b1;
            end
            if (state_reg != ST_IDLE && ev.stop_seen) begin
                set_event = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            event_flag_reg <= 1'b0;
        end else if (set_event) begin
            event_flag_reg <= 1'b1;
        end else if (wr_en && reg_hit(req.paddr, twsp_pkg::IDX_CTRL)
                     && !req.pwdata[twsp_pkg::BIT_EVENT]) begin
            event_flag_reg <= 1'b0;
        end
    end

    // byte buffer: software writes, hardware loads received bytes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            byte_buffer_reg <= twsp_pkg::RESET_BYTE;
        end else if (active && state_reg == ST_RECV && byte_done
                     && ack_allow_reg) begin
            byte_buffer_reg <= rx_byte;
        end else if (wr_en
                     && reg_hit(req.paddr, twsp_pkg::IDX_BYTE_BUF)) begin
            byte_buffer_reg <= req.pwdata[7:0];
        end
    end

    // bit counter and shifter; sampled on rising clock
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            ack_low_reg <= 1'b0;
        end else if (!active) begin
            bit_cnt_reg <= 4'h0;
        end else if (ev.start_seen) begin
            // wraps to zero on the clock fall that closes the start
            bit_cnt_reg <= '1;
        end else begin
            if (ev.clk_rise) begin
                if (bit_cnt_reg == twsp_pkg::ACK_SLOT) begin
                    ack_low_reg <= ~ev.data_lvl;
                end else if (state_reg != ST_SEND) begin
                    shift_reg <= {shift_reg[6:0], ev.data_lvl};
                end
            end
            if (ev.clk_fall) begin
                bit_cnt_reg <= nine_done ? 4'h0 : bit_cnt_reg + 4'h1;
            end
        end
    end

    // phase machine
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg              <= ST_IDLE;
            broadcast_hit_flag_reg <= 1'b0;
        end else if (!active) begin
            state_reg              <= ST_IDLE;
            broadcast_hit_flag_reg <= 1'b0;
        end else if (ev.start_seen) begin
            state_reg <= ST_ADDR;
            broadcast_hit_flag_reg <= 1'b0;
        end else if (ev.stop_seen) begin
            state_reg <= ST_IDLE;
            broadcast_hit_flag_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done) begin
                        if (addr_hit && rx_byte[0]) begin
                            state_reg <= ST_SEND;
                        end else if (addr_hit) begin
                            state_reg <= ST_RECV;
                        end else if (gc_hit) begin
                            state_reg <= ST_RECV;
                            broadcast_hit_flag_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RECV: begin
                    if (nine_done && !ack_allow_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SEND: begin
                    if (nine_done && !ack_low_reg) begin
                        state_reg <= ST_NACK_WAIT;
                    end else if (nine_done && !ack_allow_reg) begin
                        state_reg <= ST_AA_WAIT;
                    end
                end
                ST_NACK_WAIT, ST_AA_WAIT, ST_IDLE: begin
                    state_reg <= state_reg;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // data pin driver: changes on falling clock; released at start, stop or when inactive
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            drive_low_reg <= 1'b0;
            ack_slot_reg  <= 1'b0;
        end else if (!active || ev.start_seen || ev.stop_seen) begin
            drive_low_reg <= 1'b0;
            ack_slot_reg  <= 1'b0;
        end else if (ev.clk_fall) begin
            drive_low_reg <= 1'b0;
            ack_slot_reg  <= 1'b0;
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done && (addr_hit || gc_hit)) begin
                        drive_low_reg <= 1'b1;
                        ack_slot_reg  <= 1'b1;
                    end
                end
                ST_RECV: begin
                    if (byte_done && ack_allow_reg) begin
                        drive_low_reg <= 1'b1;
                        ack_slot_reg  <= 1'b1;
                    end
                end
                ST_SEND: begin
                    if (!byte_done && !nine_done) begin
                        drive_low_reg <=
                            ~byte_buffer_reg[3'(twsp_pkg::LAST_BIT
                                             - bit_cnt_reg - 4'h1)];
                    end else if (nine_done && ack_low_reg
                                 && ack_allow_reg) begin
                        drive_low_reg <= ~byte_buffer_reg[7];
                    end
                end
                default: drive_low_reg <= 1'b0;
            endcase
        end else if (ev.clk_rise && state_reg == ST_ADDR && byte_done) begin
            drive_low_reg <= 1'b0;
        end
    end

    // first send bit goes out on the ack fall after address
    // open drain: output fixed low, release via enable
    assign sda_o   = 1'b0;
    assign sda_oen = ~drive_low_reg;
endmodule : twsp_top

// ===== bench/twsp_props.sv
/*
 checker on the ports of twsp_top: apb answers and data line handling.
 assumes: bound to every twsp_top, one sys_clk domain, rstn active low.
*/
`timescale 1ns/100ps
module twsp_props (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [31:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_i,
    input wire logic        sda_o,
    input wire logic        sda_oen
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_line_never_high: assert property (!sda_o)
        else $error("data line driven high");
    a_reset_release: assert property ($rose(rstn) |-> sda_oen [*3])
        else $error("data line pulled right after reset");
    a_oen_scl_low: assert property ($changed(sda_oen) |->
        !scl_i && !$past(scl_i))
        else $error("data drive changed near clock high");
    a_hold_scl_high: assert property (!sda_oen && scl_i |=> !sda_oen)
        else $error("pull released while clock high");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access not answered");
    a_err_unmapped: assert property (psel && penable &&
        paddr[31:4] != 28'h000_0000 |-> pslverr)
        else $error("unmapped access not refused");
    a_no_err_mapped: assert property (psel && penable &&
        paddr[31:4] == 28'h000_0000 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (psel && penable && !pwrite |->
        prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_refused_rd_zero: assert property (psel && penable && !pwrite &&
        pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
endmodule : twsp_props

bind twsp_top twsp_props u_props (
    .sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .scl_i, .sda_o, .sda_oen
);

// ===== bench/twsp_master_model.sv
/*
 two-wire bus master model: clock, conditions, byte write and read.
 assumes: sda is the wired line with pull-up; 16 sys_clk per bit.
*/
`timescale 1ns/100ps
module twsp_master_model (
    input  wire logic sys_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // clock rests high outside frames, line released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic q();
        repeat (4) @(posedge sys_clk);
    endtask : q

    // data set mid low half, sampled mid high half
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_low <= !b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
    endtask : bit_io

    task automatic start();
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
    endtask : start

    task automatic rstart();
        q();
        sda_low <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
    endtask : rstart

    task automatic stop();
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
    endtask : stop

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask : wbyte

    task automatic rbyte(output logic [7:0] d, input logic mack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(mack, r);
    endtask : rbyte
endmodule : twsp_master_model

// ===== bench/twsp_tb.sv
/*
 testbench for twsp_top: apb register access and two-wire transfers.
 assumes: twsp_master_model drives the bus; pull-up on the data line.
*/
`timescale 1ns/100ps
module twsp_tb;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [31:0] paddr   = 32'h0000_0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sda_o;
    logic        sda_oen;
    logic        scl;
    logic        sda_low;
    wire         sda = !(sda_low || (!sda_oen && !sda_o));
    logic [31:0] rd;
    logic        er;
    logic        ack;
    logic [7:0]  d;
    int          n_fail   = 0;
    int          n_checks = 0;

    always #5 sys_clk = ~sys_clk;

    twsp_top dut_u (
        .sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .scl_i(scl),
        .sda_i(sda), .sda_o, .sda_oen
    );

    twsp_master_model mst (.sys_clk, .sda, .scl, .sda_low);

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, dat);
        int i;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= 32'(a);
        pwdata  <= 32'(dat);
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, dat);
        apb(1'b1, a, dat);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, exp);
        apb(1'b0, a, 8'h00);
        chk(nm, rd[7:0], exp);
    endtask : rdc

    // lets the synchronised line events settle first
    task automatic ctl(input logic [7:0] exp);
        repeat (8) @(posedge sys_clk);
        rdc("control", 8'h00, exp);
    endtask : ctl

    initial begin
        #500000;
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rdc("control", 8'h00, 8'h00);
        rdc("own addr", 8'h04, 8'h00);
        rdc("buffer", 8'h08, 8'h00);
        rdc("func", 8'h0C, 8'h00);
        rdc("unmapped", 8'h40, 8'h00);
        chk("unmapped err", 8'(er), 8'h01);
        wr(8'h08, 8'hA5);
        rdc("buffer", 8'h08, 8'hA5);
        $display("test registers done");
        wr(8'h0C, 8'h02);
        wr(8'h00, 8'h88);
        wr(8'h04, 8'h59);
        mst.start();
        ctl(8'h89);
        mst.wbyte(8'h58, ack);
        chk("addr ack", 8'(ack), 8'h00);
        ctl(8'hCA);
        wr(8'h00, 8'h88);
        mst.wbyte(8'h3C, ack);
        chk("data ack", 8'(ack), 8'h00);
        ctl(8'hCA);
        rdc("rx byte", 8'h08, 8'h3C);
        wr(8'h00, 8'h88);
        // next msb leaves at the ack fall: both bytes share bit 7
        wr(8'h08, 8'h69);
        mst.rstart();
        ctl(8'hC9);
        wr(8'h00, 8'h88);
        mst.wbyte(8'h59, ack);
        chk("rd addr ack", 8'(ack), 8'h00);
        ctl(8'hCB);
        wr(8'h00, 8'h88);
        mst.rbyte(d, 1'b0);
        chk("tx byte", d, 8'h69);
        ctl(8'hCB);
        wr(8'h00, 8'h88);
        wr(8'h08, 8'h5A);
        mst.rbyte(d, 1'b1);
        chk("tx byte", d, 8'h5A);
        ctl(8'hCC);
        wr(8'h00, 8'h88);
        mst.stop();
        ctl(8'hC8);
        $display("test transfers done");
        mst.start();
        mst.wbyte(8'h59, ack);
        wr(8'h00, 8'h80);
        mst.rbyte(d, 1'b0);
        chk("tx byte", d, 8'h5A);
        ctl(8'hC5);
        mst.stop();
        wr(8'h00, 8'h88);
        mst.start();
        mst.wbyte(8'h22, ack);
        chk("foreign nack", 8'(ack), 8'h01);
        ctl(8'h88);
        mst.stop();
        $display("test ack allow done");
        wr(8'h00, 8'h88);
        mst.start();
        mst.wbyte(8'h00, ack);
        chk("gc ack", 8'(ack), 8'h00);
        ctl(8'hDA);
        wr(8'h00, 8'h80);
        mst.wbyte(8'h77, ack);
        chk("refuse nack", 8'(ack), 8'h01);
        repeat (8) @(posedge sys_clk);
        apb(1'b0, 8'h00, 8'h00);
        chk("phase", 8'(rd[2:0]), 8'h00);
        rdc("buffer kept", 8'h08, 8'h5A);
        mst.stop();
        $display("test general call done");
        stop_test();
    end
endmodule : twsp_tb
